//--- core/bsc_branch_sequence_control.sv
`timescale 1ns/100ps
`include "bsc_defines.svh"

module bsc_branch_sequence_control (
  input  wire logic        clk_sys,
  input  wire logic        srst,
  input  wire logic        issue_valid,
  input  wire logic [5:0]  opcode_field,
  input  wire logic [2:0]  i_field,
  input  wire logic [17:0] k_constant,
  input  wire logic [17:0] index_operand_register,
  input  wire logic        parcel_advance,
  input  wire logic        stack_input_word_valid,
  input  wire logic        aux_release,
  input  wire logic        x_test_nonzero,
  input  wire logic        x_test_negative,
  input  wire logic        x_test_out_range,
  input  wire logic        x_test_indefinite,
  input  wire logic        b_test_equal,
  input  wire logic        b_test_negative,
  input  wire logic        mem_accept,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic             issue_hold,
  output logic             proceed,
  output logic [17:0]      program_address,
  output logic [2:0]       stack_position,
  output logic [2:0]       depth,
  output logic [1:0]       parcel_counter,
  output logic             mem_req,
  output logic             mem_write,
  output logic [17:0]      mem_addr,
  output logic [3:0]       mem_tag,
  output logic [59:0]      mem_wdata,
  output logic [31:0]      reg_rdata
);

  bsc_pkg::bsc_state_t state_reg;
  bsc_pkg::bsc_state_t state_next;
  logic [17:0] prog_addr_reg;
  logic [17:0] prog_addr_next;
  logic [17:0] save_reg;
  logic [17:0] save_next;
  logic [17:0] target_reg;
  logic [17:0] target_next;
  logic [2:0]  depth_reg;
  logic [2:0]  depth_next;
  logic [2:0]  stack_pos_reg;
  logic [2:0]  stack_pos_next;
  logic [1:0]  parcel_reg;
  logic [1:0]  parcel_next;
  logic        hold_reg;
  logic        hold_next;
  logic        proceed_reg;
  logic        proceed_next;
  logic        mem_req_reg;
  logic        mem_req_next;
  logic        mem_write_reg;
  logic        mem_write_next;
  logic [17:0] mem_addr_reg;
  logic [17:0] mem_addr_next;
  logic [3:0]  mem_tag_reg;
  logic [3:0]  mem_tag_next;
  logic [59:0] mem_wdata_reg;
  logic [59:0] mem_wdata_next;
  logic [5:0]  op_reg;
  logic [5:0]  op_next;
  logic [2:0]  sub_reg;
  logic [2:0]  sub_next;
  logic        force_out_reg;
  logic [31:0] rdata_reg;

  // Condition decode; test sources differ by opcode group
  function automatic logic bsc_cond_met(
    input logic [5:0] op,
    input logic [2:0] sub,
    input logic       xnz,
    input logic       xneg,
    input logic       xoor,
    input logic       xind,
    input logic       beq,
    input logic       bneg
  );
    logic met;
    met = 1'b0;
    case (op)
      `BSC_OP_X_TEST: begin
        case (sub)
          `BSC_X_ZERO:       met = ~xnz;
          `BSC_X_NONZERO:    met = xnz;
          `BSC_X_POSITIVE:   met = ~xneg;
          `BSC_X_NEGATIVE:   met = xneg;
          `BSC_X_IN_RANGE:   met = ~xoor;
          `BSC_X_OUT_RANGE:  met = xoor;
          `BSC_X_DEFINITE:   met = ~xind;
          default:           met = xind;
        endcase
      end
      `BSC_OP_B_EQUAL:      met = beq;
      `BSC_OP_B_NOT_EQUAL:  met = ~beq;
      `BSC_OP_B_GREATER_EQ: met = ~bneg;
      `BSC_OP_B_LESS:       met = bneg;
      default:              met = 1'b0;
    endcase
    return met;
  endfunction

  // Opcode class decode on the issued instruction
  wire        op_is_branch = (opcode_field[5:3] == `BSC_CLASS_DIGIT);
  wire        op_is_return = (opcode_field == `BSC_OP_RETURN_JUMP);
  wire        op_is_indexed = (opcode_field == `BSC_OP_INDEXED_JUMP);
  wire        op_is_cond = (opcode_field >= `BSC_OP_X_TEST);
  wire        op_accept = issue_valid && op_is_branch
                          && (op_is_return || op_is_indexed || op_is_cond);

  // Indexed target: constant alone when no index register
  wire [17:0] indexed_target = (i_field == `BSC_INDEX_NONE) ? k_constant
                               : (index_operand_register + k_constant);

  // Stack reach test on the held target
  wire [17:0] disp = target_reg - prog_addr_reg;
  wire        backward = disp[17];
  wire [17:0] disp_mag = backward ? (~disp + 18'h00001) : disp;
  wire        mag_ok = (disp_mag <= `BSC_STACK_REACH);
  wire [2:0]  disp_step = disp_mag[2:0];
  // Position holds complement of word number, so room forward is ~L
  wire        reach_ok = backward ? (disp_step <= stack_pos_reg)
                         : (disp_step <= ~stack_pos_reg);
  // Backward target must belong to this routine; forward needs no check
  wire        depth_ok = backward ? (depth_reg == `BSC_DEPTH_FULL)
                         : 1'b1;
  wire        in_stack = mag_ok && reach_ok && depth_ok && ~force_out_reg;
  wire [2:0]  new_pos = backward ? (stack_pos_reg - disp_step)
                        : (stack_pos_reg + disp_step);

  // Single condition outcome from the returned tests
  wire        cond_met = bsc_cond_met(op_reg, sub_reg, x_test_nonzero,
                                      x_test_negative, x_test_out_range,
                                      x_test_indefinite, b_test_equal,
                                      b_test_negative);

  // Register port decode
  wire        wr_ctrl = reg_wr && (reg_addr == `BSC_REG_CTRL);
  wire        wr_paddr = reg_wr && (reg_addr == `BSC_REG_PADDR);
  wire [31:0] status_word = {21'h000000, (state_reg != bsc_pkg::BSC_IDLE),
                             hold_reg, mem_req_reg, depth_reg,
                             stack_pos_reg, parcel_reg};
  wire [31:0] read_sel;
  assign read_sel = (reg_addr == `BSC_REG_CTRL)   ? {31'h00000000, force_out_reg}
                  : (reg_addr == `BSC_REG_STATUS) ? status_word
                  : (reg_addr == `BSC_REG_PADDR)  ? {14'h0000, prog_addr_reg}
                  : (reg_addr == `BSC_REG_TARGET) ? {14'h0000, target_reg}
                  : 32'h00000000;

  // Sequencer and stack control next values
  always_comb begin
    state_next     = state_reg;
    prog_addr_next = prog_addr_reg;
    save_next      = save_reg;
    target_next    = target_reg;
    stack_pos_next = stack_pos_reg;
    hold_next      = hold_reg;
    proceed_next   = 1'b0;
    mem_req_next   = mem_req_reg;
    mem_write_next = mem_write_reg;
    mem_addr_next  = mem_addr_reg;
    mem_tag_next   = mem_tag_reg;
    mem_wdata_next = mem_wdata_reg;
    op_next        = op_reg;
    sub_next       = sub_reg;
    // Words entering the stack raise the routine count
    depth_next = (stack_input_word_valid && (depth_reg != `BSC_DEPTH_FULL))
                 ? (depth_reg - 3'h1) : depth_reg;
    parcel_next = parcel_advance ? (parcel_reg + 2'h1) : parcel_reg;
    case (state_reg)
      bsc_pkg::BSC_IDLE: begin
        if (op_accept) begin
          hold_next = 1'b1;
          op_next   = opcode_field;
          sub_next  = i_field;
          if (op_is_return) begin
            // Save return address, then store jump word at target
            save_next      = prog_addr_reg;
            prog_addr_next = k_constant;
            target_next    = k_constant;
            mem_req_next   = 1'b1;
            mem_write_next = 1'b1;
            mem_addr_next  = k_constant;
            mem_tag_next   = `BSC_TAG_STORE;
            mem_wdata_next = {`BSC_JUMP_OPCODE_WORD, prog_addr_reg,
                              `BSC_LOWER_HALF_ZERO};
            state_next     = bsc_pkg::BSC_RETURN_STORE;
          end else if (op_is_indexed) begin
            // Always leaves the stack
            prog_addr_next = indexed_target;
            target_next    = indexed_target;
            mem_req_next   = 1'b1;
            mem_write_next = 1'b0;
            mem_addr_next  = indexed_target;
            mem_tag_next   = `BSC_TAG_NEXT_INSTRUCTION_FETCH;
            stack_pos_next = `BSC_STACK_INPUT_POS;
            depth_next     = `BSC_DEPTH_EMPTY;
            parcel_next    = `BSC_PARCEL_ZERO;
            state_next     = bsc_pkg::BSC_WAIT_ACCEPT;
          end else begin
            target_next = k_constant;
            state_next  = bsc_pkg::BSC_WAIT_TEST;
          end
        end else if (wr_paddr) begin
          prog_addr_next = reg_wdata[17:0];
        end
      end
      bsc_pkg::BSC_WAIT_TEST: begin
        if (aux_release) begin
          if (!cond_met) begin
            // No branch: position and advanced parcel stay
            proceed_next = 1'b1;
            hold_next    = 1'b0;
            state_next   = bsc_pkg::BSC_IDLE;
          end else if (in_stack) begin
            parcel_next    = `BSC_PARCEL_ZERO;
            stack_pos_next = new_pos;
            prog_addr_next = target_reg;
            proceed_next   = 1'b1;
            hold_next      = 1'b0;
            state_next     = bsc_pkg::BSC_IDLE;
          end else begin
            prog_addr_next = target_reg;
            mem_req_next   = 1'b1;
            mem_write_next = 1'b0;
            mem_addr_next  = target_reg;
            mem_tag_next   = `BSC_TAG_NEXT_INSTRUCTION_FETCH;
            stack_pos_next = `BSC_STACK_INPUT_POS;
            depth_next     = `BSC_DEPTH_EMPTY;
            parcel_next    = `BSC_PARCEL_ZERO;
            state_next     = bsc_pkg::BSC_WAIT_ACCEPT;
          end
        end
      end
      bsc_pkg::BSC_RETURN_STORE: begin
        if (mem_accept) begin
          // Store taken; fetch continues at target plus one
          prog_addr_next = prog_addr_reg + 18'h00001;
          mem_write_next = 1'b0;
          mem_addr_next  = prog_addr_reg + 18'h00001;
          mem_tag_next   = `BSC_TAG_NEXT_INSTRUCTION_FETCH;
          stack_pos_next = `BSC_STACK_INPUT_POS;
          depth_next     = `BSC_DEPTH_EMPTY;
          parcel_next    = `BSC_PARCEL_ZERO;
          state_next     = bsc_pkg::BSC_WAIT_ACCEPT;
        end
      end
      bsc_pkg::BSC_WAIT_ACCEPT: begin
        // Issue resumes only once the fetch address is accepted
        if (mem_accept) begin
          mem_req_next = 1'b0;
          proceed_next = 1'b1;
          hold_next    = 1'b0;
          state_next   = bsc_pkg::BSC_IDLE;
        end
      end
      default: begin
        state_next = bsc_pkg::BSC_IDLE;
      end
    endcase
  end

  // Sequencer state and operand capture
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_reg <= bsc_pkg::BSC_IDLE;
      op_reg    <= 6'h00;
      sub_reg   <= 3'h0;
    end else begin
      state_reg <= state_next;
      op_reg    <= op_next;
      sub_reg   <= sub_next;
    end
  end

  // Program address, save and target registers
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      prog_addr_reg <= 18'h00000;
      save_reg      <= 18'h00000;
      target_reg    <= 18'h00000;
    end else begin
      prog_addr_reg <= prog_addr_next;
      save_reg      <= save_next;
      target_reg    <= target_next;
    end
  end

  // Stack controls start empty, pointing at the input word
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      depth_reg     <= `BSC_DEPTH_EMPTY;
      stack_pos_reg <= `BSC_STACK_INPUT_POS;
      parcel_reg    <= `BSC_PARCEL_ZERO;
    end else begin
      depth_reg     <= depth_next;
      stack_pos_reg <= stack_pos_next;
      parcel_reg    <= parcel_next;
    end
  end

  // Issue handshake
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      hold_reg    <= 1'b0;
      proceed_reg <= 1'b0;
    end else begin
      hold_reg    <= hold_next;
      proceed_reg <= proceed_next;
    end
  end

  // Memory request held until accepted
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      mem_req_reg   <= 1'b0;
      mem_write_reg <= 1'b0;
      mem_addr_reg  <= 18'h00000;
      mem_tag_reg   <= `BSC_TAG_STORE;
      mem_wdata_reg <= 60'h000000000000000;
    end else begin
      mem_req_reg   <= mem_req_next;
      mem_write_reg <= mem_write_next;
      mem_addr_reg  <= mem_addr_next;
      mem_tag_reg   <= mem_tag_next;
      mem_wdata_reg <= mem_wdata_next;
    end
  end

  // Control bit and read data; data only in the cycle after the strobe
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      force_out_reg <= 1'b0;
      rdata_reg     <= 32'h00000000;
    end else begin
      if (wr_ctrl) begin
        force_out_reg <= reg_wdata[`BSC_CTRL_FORCE_OUT];
      end
      rdata_reg <= reg_rd ? read_sel : 32'h00000000;
    end
  end

  assign issue_hold      = hold_reg;
  assign proceed         = proceed_reg;
  assign program_address = prog_addr_reg;
  assign stack_position  = stack_pos_reg;
  assign depth           = depth_reg;
  assign parcel_counter  = parcel_reg;
  assign mem_req         = mem_req_reg;
  assign mem_write       = mem_write_reg;
  assign mem_addr        = mem_addr_reg;
  assign mem_tag         = mem_tag_reg;
  assign mem_wdata       = mem_wdata_reg;
  assign reg_rdata       = rdata_reg;

endmodule

//--- core/bsc_defines.svh
// Function
// - Handle only opcodes whose high digit is zero
// - Unconditional branch loads address, fetches target word
// - Unconditional branch: parcel zero, depth and position 7
// - X tests from long add, B tests increment
// - AND test results with decoded opcode
// - In stack needs displacement magnitude at most 7
// - Target word must be inside physical stack
// - Depth zero full, 7 empty, decrement per word
// - Depth holds complement of current routine word count
// - Backward in-stack branch needs depth zero
// - Forward in-stack branch ignores depth
// - Not met: proceed only, position and parcel kept
// - In stack: clear parcel, new position, address, proceed
// - Out of stack: address, fetch, stack controls reset
// - Return jump stores jump opcode plus return address
// - Return jump ordered save, write, increment, fetch, await
// - Indexed jump targets index register plus constant
// - Indexed jump always out of stack, await acceptance
// - X opcodes 030 to 036 decode fixed tests
// - Opcode 037 jumps on indefinite operand
// - Opcodes 04 to 07 compare two B registers
// - Outcome and stack test select one path
`ifndef BSC_DEFINES_SVH
`define BSC_DEFINES_SVH

// Opcode field values of the branch class
`define BSC_CLASS_DIGIT       3'h0
`define BSC_OP_RETURN_JUMP    6'h01
`define BSC_OP_INDEXED_JUMP   6'h02
`define BSC_OP_X_TEST         6'h03
`define BSC_OP_B_EQUAL        6'h04
`define BSC_OP_B_NOT_EQUAL    6'h05
`define BSC_OP_B_GREATER_EQ   6'h06
`define BSC_OP_B_LESS         6'h07

// Sub-codes of the X test group (i digit)
`define BSC_X_ZERO            3'h0
`define BSC_X_NONZERO         3'h1
`define BSC_X_POSITIVE        3'h2
`define BSC_X_NEGATIVE        3'h3
`define BSC_X_IN_RANGE        3'h4
`define BSC_X_OUT_RANGE       3'h5
`define BSC_X_DEFINITE        3'h6
`define BSC_X_INDEFINITE      3'h7

// Stack control values
`define BSC_STACK_INPUT_POS   3'h7
`define BSC_DEPTH_EMPTY       3'h7
`define BSC_DEPTH_FULL        3'h0
`define BSC_PARCEL_ZERO       2'h0
`define BSC_STACK_REACH       18'h00007
`define BSC_INDEX_NONE        3'h0

// Memory request tags and stored jump word
`define BSC_TAG_STORE         4'h0
`define BSC_TAG_NEXT_INSTRUCTION_FETCH 4'h8
`define BSC_JUMP_OPCODE_WORD  12'h100
`define BSC_LOWER_HALF_ZERO   30'h00000000

// Register port offsets
`define BSC_REG_CTRL          4'h0
`define BSC_REG_STATUS        4'h4
`define BSC_REG_PADDR         4'h8
`define BSC_REG_TARGET        4'hC
`define BSC_CTRL_FORCE_OUT    0

`endif

//--- core/bsc_pkg.sv
package bsc_pkg;

  // Sequencer states of the branch unit
  typedef enum logic [2:0] {
    BSC_IDLE,
    BSC_WAIT_TEST,
    BSC_RETURN_STORE,
    BSC_WAIT_ACCEPT
  } bsc_state_t;

endpackage

//--- tb/branch_sequence_control_test.sv
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin err_total++; \
  $display("ERROR %s expected %h seen %h", nm, ex, got); end end

module branch_sequence_control_test;
  logic clk_sys, srst, issue_valid, parcel_advance, aux_release, mem_accept, reg_wr, reg_rd;
  logic x_test_nonzero, x_test_negative, x_test_out_range, x_test_indefinite;
  logic b_test_equal, b_test_negative, stack_input_word_valid, fill_req, rd_q;
  logic issue_hold, proceed, mem_req, mem_write, force_m;
  logic [5:0]  opcode_field;
  logic [2:0]  i_field, stack_position, depth, pos_m, dep_m;
  logic [17:0] k_constant, index_operand_register, program_address, mem_addr, p_m;
  logic [1:0]  parcel_counter, par_m, accept_delay;
  logic [3:0]  reg_addr, mem_tag;
  logic [31:0] reg_wdata, reg_rdata, e_rd;
  logic [59:0] mem_wdata;
  logic [25:0] e_proc;
  logic [82:0] e_mem;
  logic [25:0] q_proc[$];
  logic [82:0] q_mem[$];
  logic [31:0] q_rd[$];
  int err_total, n_compared;

  bsc_branch_sequence_control uut (.clk_sys(clk_sys), .srst(srst), .issue_valid(issue_valid),
    .opcode_field(opcode_field), .i_field(i_field), .k_constant(k_constant),
    .index_operand_register(index_operand_register), .parcel_advance(parcel_advance),
    .stack_input_word_valid(stack_input_word_valid), .aux_release(aux_release),
    .x_test_nonzero(x_test_nonzero), .x_test_negative(x_test_negative),
    .x_test_out_range(x_test_out_range), .x_test_indefinite(x_test_indefinite),
    .b_test_equal(b_test_equal), .b_test_negative(b_test_negative), .mem_accept(mem_accept),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .issue_hold(issue_hold), .proceed(proceed), .program_address(program_address),
    .stack_position(stack_position), .depth(depth), .parcel_counter(parcel_counter),
    .mem_req(mem_req), .mem_write(mem_write), .mem_addr(mem_addr), .mem_tag(mem_tag),
    .mem_wdata(mem_wdata), .reg_rdata(reg_rdata));

  bsc_mem_partner u_mem (.clk_sys(clk_sys), .srst(srst), .mem_req(mem_req),
    .mem_write(mem_write), .accept_delay(accept_delay), .fill_req(fill_req),
    .mem_accept(mem_accept), .stack_input_word_valid(stack_input_word_valid));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  function automatic logic [31:0] st();
    return {21'h0, 3'h0, dep_m, pos_m, par_m};
  endfunction

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys); reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge clk_sys); reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] ex);
    q_rd.push_back(ex);
    @(posedge clk_sys); reg_addr <= a; reg_rd <= 1'b1;
    @(posedge clk_sys); reg_rd <= 1'b0;
  endtask

  // Pulses of parcel advance or stack word entry while idle
  task automatic pulse(input logic adv, input int n);
    repeat (n) begin
      @(posedge clk_sys); parcel_advance <= adv; fill_req <= !adv;
      @(posedge clk_sys); parcel_advance <= 1'b0; fill_req <= 1'b0;
      if (adv) par_m = par_m + 2'h1;
      else if (dep_m != 3'h0) dep_m = dep_m - 3'h1;
    end
  endtask

  // One branch; expectations noted before the outputs can show them
  task automatic br(input logic [5:0] op, input logic [2:0] sub, input logic [17:0] k,
                    input logic [17:0] bi, input logic [5:0] t);
    logic met, inst;
    logic [17:0] d, m, tgt;
    d = k - p_m;
    m = d[17] ? -d : d;
    met = (op == 6'h03) ? (t[sub[2:1]] ^ ~sub[0]) : op[1] ? t[5] ^ ~op[0] : t[4] ^ op[0];
    if (op < 6'h03) met = 1'b1;
    inst = op > 6'h02 && !force_m && m <= 18'h7 &&
      (d[17] ? (m <= {15'h0, pos_m} && dep_m == 3'h0) : m <= {15'h0, ~pos_m});
    tgt = (op == 6'h02) ? (sub == 3'h0 ? k : bi + k) : (op == 6'h01 ? k + 18'h1 : k);
    if (met && inst) begin
      p_m = k; pos_m = pos_m + d[2:0]; par_m = 2'h0;
    end else if (met) begin
      if (op == 6'h01) q_mem.push_back({1'b1, k, 4'h0, 12'h100, p_m, 30'h0});
      q_mem.push_back({1'b0, tgt, 4'h8, 60'h0});
      p_m = tgt; pos_m = 3'h7; dep_m = 3'h7; par_m = 2'h0;
    end
    q_proc.push_back({p_m, pos_m, par_m, dep_m});
    if (met && !inst) dep_m = 3'h6;
    @(posedge clk_sys); issue_valid <= 1'b1; opcode_field <= op; i_field <= sub;
    k_constant <= k; index_operand_register <= bi; accept_delay <= 2'($urandom);
    @(posedge clk_sys); issue_valid <= 1'b0;
    if (op > 6'h02) begin
      repeat (2) @(posedge clk_sys);
      aux_release <= 1'b1;
      {b_test_negative, b_test_equal, x_test_indefinite, x_test_out_range,
       x_test_negative, x_test_nonzero} <= t;
      @(posedge clk_sys); aux_release <= 1'b0;
    end
    for (int c = 0; c < 200 && proceed !== 1'b1; c++) @(posedge clk_sys);
    repeat (4) @(posedge clk_sys);
  endtask

  // Watcher: oldest note against each appearing result
  always @(posedge clk_sys) begin
    rd_q <= reg_rd;
    if (rd_q === 1'b1) begin
      e_rd = q_rd.pop_front();
      `CHK("reg_rdata", e_rd, reg_rdata)
    end
    if (proceed === 1'b1) begin
      e_proc = (q_proc.size() > 0) ? q_proc.pop_front() : 26'h0;
      `CHK("state_at_proceed", e_proc,
           {program_address, stack_position, parcel_counter, depth})
    end
    if (mem_accept === 1'b1 && mem_req === 1'b1) begin
      e_mem = (q_mem.size() > 0) ? q_mem.pop_front() : 83'h0;
      `CHK("mem_request", e_mem[82:60], {mem_write, mem_addr, mem_tag})
      if (e_mem[82]) `CHK("mem_wdata", e_mem[59:0], mem_wdata)
    end
  end

  initial begin
    #200000;
    err_total++;
    conclude();
  end

  initial begin
    {srst, issue_valid, parcel_advance, aux_release, reg_wr, reg_rd, fill_req} = 7'h40;
    {x_test_nonzero, x_test_negative, x_test_out_range, x_test_indefinite} = 4'h0;
    {b_test_equal, b_test_negative, force_m} = 3'h0;
    opcode_field = 6'h00; i_field = 3'h0; k_constant = 18'h0; index_operand_register = 18'h0;
    reg_addr = 4'h0; reg_wdata = 32'h0; accept_delay = 2'h0;
    err_total = 0; n_compared = 0;
    p_m = 18'h0; pos_m = 3'h7; dep_m = 3'h7; par_m = 2'h0;
    void'($urandom(32'hFE04EEA8));
    repeat (4) @(posedge clk_sys);
    srst <= 1'b0;
    rd(4'h4, st());
    wr(4'h8, 32'h00012340); p_m = 18'h12340;
    rd(4'h8, 32'h00012340);
    rd(4'h2, 32'h0);
    wr(4'h4, 32'hFFFFFFFF);
    rd(4'h4, st());
    $display("test registers done");
    for (int j = 0; j < 3; j++) begin
      @(posedge clk_sys); issue_valid <= 1'b1; opcode_field <= 6'(18'h0043F >> (6 * j));
      @(posedge clk_sys); issue_valid <= 1'b0;
      rd(4'h4, st());
    end
    $display("test foreign opcodes done");
    pulse(1'b1, 2); br(6'h02, 3'h0, 18'($urandom), 18'($urandom), 6'h0);
    pulse(1'b1, 1); br(6'h02, 3'h5, 18'($urandom), 18'($urandom), 6'h0);
    pulse(1'b1, 3); br(6'h01, 3'h0, 18'($urandom), 18'h0, 6'h0);
    $display("test unconditional done");
    for (int s = 0; s < 8; s++) begin
      pulse(1'b1, 1); br(6'h03, 3'(s), p_m, 18'h0, 6'($urandom));
    end
    for (int o = 4; o < 8; o++) begin
      pulse(1'b1, 1); br(6'(o), 3'h0, p_m, 18'h0, 6'($urandom));
    end
    $display("test conditions done");
    pulse(1'b0, 8); rd(4'h4, st());
    br(6'h04, 3'h0, p_m - 18'h3, 18'h0, 6'h10);
    br(6'h04, 3'h0, p_m + 18'h4, 18'h0, 6'h10);
    br(6'h04, 3'h0, p_m - 18'h2, 18'h0, 6'h10);
    pulse(1'b0, 8); br(6'h04, 3'h0, p_m - 18'h8, 18'h0, 6'h10);
    pulse(1'b0, 8); br(6'h04, 3'h0, p_m - 18'h7, 18'h0, 6'h10);
    br(6'h04, 3'h0, p_m + 18'h7, 18'h0, 6'h10);
    br(6'h04, 3'h0, p_m + 18'h8, 18'h0, 6'h10);
    $display("test stack reach done");
    wr(4'h0, 32'h1); force_m = 1'b1; rd(4'h0, 32'h1);
    pulse(1'b1, 1); br(6'h05, 3'h0, p_m, 18'h0, 6'h00);
    wr(4'h0, 32'h0); force_m = 1'b0;
    $display("test forced fetch done");
    repeat (4) @(posedge clk_sys);
    `CHK("notes_left", 0, q_proc.size() + q_mem.size() + q_rd.size())
    conclude();
  end
endmodule

//--- tb/bsc_branch_properties.sv
`timescale 1ns/100ps

module bsc_branch_properties (
  input wire logic        clk_sys,
  input wire logic        srst,
  input wire logic        issue_valid,
  input wire logic [5:0]  opcode_field,
  input wire logic        stack_input_word_valid,
  input wire logic        mem_accept,
  input wire logic        issue_hold,
  input wire logic        proceed,
  input wire logic [17:0] program_address,
  input wire logic [2:0]  stack_position,
  input wire logic [2:0]  depth,
  input wire logic [1:0]  parcel_counter,
  input wire logic        mem_req,
  input wire logic        mem_write,
  input wire logic [17:0] mem_addr,
  input wire logic [3:0]  mem_tag,
  input wire logic [59:0] mem_wdata
);
  // One clock domain, so one clocking and one reset for all
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  property p_pulse; proceed |=> !proceed; endproperty
  a_pulse: assert property (p_pulse) else $error("proceed longer than one cycle");
  property p_hold_end; $fell(issue_hold) |-> proceed; endproperty
  a_hold_end: assert property (p_hold_end) else $error("hold dropped without proceed");
  property p_take;
    issue_valid && !issue_hold && opcode_field[5:3] == 3'h0 && opcode_field != 6'h00
      |=> issue_hold;
  endproperty
  a_take: assert property (p_take) else $error("branch opcode not taken");
  property p_ignore; issue_valid && !issue_hold && opcode_field[5:3] != 3'h0 |=> !issue_hold;
  endproperty
  a_ignore: assert property (p_ignore) else $error("foreign opcode taken");
  property p_out_set;
    $rose(mem_req) && !mem_write |-> stack_position == 3'h7 && depth == 3'h7 &&
      parcel_counter == 2'h0 && program_address == mem_addr && mem_tag == 4'h8;
  endproperty
  a_out_set: assert property (p_out_set) else $error("fetch without stack reset");
  property p_rj_word;
    mem_write |-> mem_req && mem_tag == 4'h0 && mem_wdata[59:48] == 12'h100 &&
      mem_wdata[29:0] == 30'h0;
  endproperty
  a_rj_word: assert property (p_rj_word) else $error("bad stored jump word");
  property p_rj_next;
    mem_write && mem_accept |=> mem_req && !mem_write && mem_tag == 4'h8 &&
      mem_addr == $past(mem_addr) + 18'h1 && program_address == mem_addr;
  endproperty
  a_rj_next: assert property (p_rj_next) else $error("no fetch of target plus one");
  property p_fetch_done; mem_accept && !mem_write |=> proceed && !mem_req; endproperty
  a_fetch_done: assert property (p_fetch_done) else $error("no proceed after accept");
  property p_wait_accept; issue_hold && mem_req && !mem_accept |=> !proceed; endproperty
  a_wait_accept: assert property (p_wait_accept) else $error("proceed before accept");
  property p_depth;
    stack_input_word_valid && !issue_hold && !issue_valid && !mem_req && depth != 3'h0
      |=> depth == $past(depth) - 3'h1;
  endproperty
  a_depth: assert property (p_depth) else $error("depth not decremented");
  property p_sat; stack_input_word_valid && !issue_hold && !issue_valid && depth == 3'h0
      |=> depth == 3'h0;
  endproperty
  a_sat: assert property (p_sat) else $error("full depth wrapped");
endmodule

bind bsc_branch_sequence_control bsc_branch_properties u_props (
  .clk_sys(clk_sys), .srst(srst), .issue_valid(issue_valid), .opcode_field(opcode_field),
  .stack_input_word_valid(stack_input_word_valid), .mem_accept(mem_accept),
  .issue_hold(issue_hold), .proceed(proceed), .program_address(program_address),
  .stack_position(stack_position), .depth(depth), .parcel_counter(parcel_counter),
  .mem_req(mem_req), .mem_write(mem_write), .mem_addr(mem_addr), .mem_tag(mem_tag),
  .mem_wdata(mem_wdata)
);

//--- tb/bsc_mem_partner.sv
`timescale 1ns/100ps

module bsc_mem_partner (
  input wire logic       clk_sys,
  input wire logic       srst,
  input wire logic       mem_req,
  input wire logic       mem_write,
  input wire logic [1:0] accept_delay,
  input wire logic       fill_req,
  output logic           mem_accept,
  output logic           stack_input_word_valid
);
  logic [1:0] wait_reg;
  logic [1:0] ret_reg;
  logic       word_reg;

  // Accept a standing request after a chosen delay; word returns late, never early
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      mem_accept <= 1'b0;
      wait_reg   <= 2'h0;
      ret_reg    <= 2'h0;
      word_reg   <= 1'b0;
    end else begin
      word_reg <= (ret_reg == 2'h1);
      if (mem_accept) begin
        mem_accept <= 1'b0;
        wait_reg   <= 2'h0;
        ret_reg    <= mem_write ? 2'h0 : 2'h2;
      end else begin
        if (ret_reg != 2'h0) ret_reg <= ret_reg - 2'h1;
        if (mem_req && wait_reg == accept_delay) mem_accept <= 1'b1;
        else if (mem_req) wait_reg <= wait_reg + 2'h1;
      end
    end
  end

  // Bench may also push words into the stack directly
  assign stack_input_word_valid = word_reg | fill_req;
endmodule
